// *** dv/mii_link_properties.sv ***
// concurrent checks on the mii/rmii pins between phy port and mac end
`timescale 1ns/1ps
`default_nettype none
module mii_link_properties #(
  parameter int MDC_HALF = 1
) (
  // clock, reset and configuration
  input wire logic clk,
  input wire logic rstn,
  input wire logic rmii_mode,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic heartbeat_en,
  // link pins
  input wire logic tx_clk,
  input wire logic rx_clk,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic crs,
  input wire logic col,
  input wire logic rx_dv,
  input wire logic rx_er,
  input wire logic [3:0] rxd,
  input wire logic mdc
);
  localparam int MDC_PER = 2 * MDC_HALF;
  logic [1:0] up_r;
  logic [7:0] run_r;
  logic [7:0] gap_r;
  logic set;
  logic sqe;
  // config only moves under reset, so three edges let the pins settle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      up_r <= 2'h0;
      run_r <= 8'h00;
      gap_r <= 8'h00;
    end
    else
    begin
      up_r <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
      run_r <= col ? run_r + 8'h01 : 8'h00;
      // cycles since the last transmit strobe, saturating so it never wraps
      gap_r <= tx_clk ? 8'h00 : ((gap_r == 8'hFF) ? gap_r : gap_r + 8'h01);
    end
  end
  assign set = (up_r == 2'h3);
  assign sqe = set && !rmii_mode && !speed_100 && !full_duplex && heartbeat_en;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rxd_idle_zero: assert property (set && !rx_dv |-> rxd == 4'h0)
    else $error("rxd not idle without rx_dv");
  a_rmii_pins_quiet: assert property (
    set && rmii_mode |-> rxd[3:2] == 2'h0 && !tx_clk && !rx_clk)
    else $error("rmii drives unused pins");
  a_rx_er_qualified: assert property (set && rx_er |-> rx_dv && speed_100)
    else $error("rx_er outside valid 100M data");
  a_er_corrupts_nibble: assert property (
    set && rx_er && !rmii_mode |-> rxd == mii_port_pkg::RX_CORRUPT)
    else $error("errored nibble not corrupted");
  a_fast_strobes: assert property (
    set && !rmii_mode && speed_100 |-> tx_clk && rx_clk)
    else $error("100M strobe missing");
  a_slow_strobe_gap: assert property (
    set && !rmii_mode && !speed_100 && tx_clk |-> gap_r == 8'(mii_port_pkg::SLOW_DIV - 1))
    else $error("10M strobe not one in ten");
  a_col_held_low: assert property (set && (rmii_mode || full_duplex) |-> !col)
    else $error("col high in full duplex or rmii");
  a_col_on_overlap: assert property (
    set && !rmii_mode && !full_duplex && speed_100
    && $past(tx_en) && tx_en && crs |-> ##[0:1] col)
    else $error("collision not flagged");
  a_hb_pulse_start: assert property (sqe && $fell(tx_en) |-> ##[1:12] col)
    else $error("heartbeat missing");
  a_hb_pulse_len: assert property (
    sqe && $fell(col) |-> run_r == 8'(mii_port_pkg::SQE_CYC))
    else $error("heartbeat length wrong");
  a_mdc_period: assert property (set && $rose(mdc) |-> ##MDC_PER $rose(mdc))
    else $error("mdc period wrong");
  a_rmii_txd_high: assert property (set && rmii_mode |-> txd[3:2] == 2'h0)
    else $error("rmii upper txd driven");
  // main scenarios reached
  c_heartbeat: cover property (sqe && $fell(col));
  c_rx_error: cover property (rx_er);
  c_collision: cover property (!full_duplex && col && crs);
  c_slow_strobe: cover property (set && !rmii_mode && !speed_100 && tx_clk);
endmodule // mii_link_properties
`default_nettype wire

// *** dv/test_phy_mii_rmii_mac_side_port.sv ***
// self-checking bench joining the phy port and the mac end
`timescale 1ns/1ps
`default_nettype none
module test_phy_mii_rmii_mac_side_port;
  logic clk, rstn, rmii_mode, speed_100, full_duplex, heartbeat_en;
  logic lr_act, lr_vld, lr_err, lr_take, lt_vld, tx_valid, tx_take, rx_valid, rx_err;
  logic [3:0] lr_nib, lt_nib, tx_nibble, rx_nibble;
  logic crs, col, col_seen, crs_seen, phy_drive, phy_bit, mac_drive, mac_bit;
  logic mgmt_mdc, mgmt_mdio, rd_bit, rd_stb;
  logic [4:0] tx_q[$], rx_q[$], got_tx[$], got_rx[$];
  int errors, comparisons;
  // {rmii, 100M, full, heartbeat, receive}
  localparam logic [4:0] CFGS [6] = '{5'h09, 5'h0F, 5'h02, 5'h07, 5'h19, 5'h15};
  mii_link_if link ();
  phy_mac_port i_phy_mac_port (.clk(clk), .rstn(rstn), .link(link),
    .line_rx_active(lr_act), .line_rx_valid(lr_vld), .line_rx_nibble(lr_nib),
    .line_rx_err(lr_err), .line_rx_take(lr_take), .line_tx_nibble(lt_nib),
    .line_tx_valid(lt_vld), .rmii_mode(rmii_mode), .speed_100(speed_100),
    .full_duplex(full_duplex), .heartbeat_en(heartbeat_en), .mgmt_drive(phy_drive),
    .mgmt_bit(phy_bit), .mgmt_mdc(mgmt_mdc), .mgmt_mdio(mgmt_mdio));
  mac_link_end #(.MDC_HALF(1)) i_mac_link_end (.clk(clk), .rstn(rstn), .link(link),
    .rmii_mode(rmii_mode), .speed_100(speed_100), .tx_valid(tx_valid),
    .tx_nibble(tx_nibble), .tx_take(tx_take), .rx_valid(rx_valid), .rx_nibble(rx_nibble),
    .rx_err(rx_err), .crs(crs), .col(col), .mgmt_drive(mac_drive), .mgmt_bit(mac_bit),
    .mgmt_rd_bit(rd_bit), .mgmt_rd_stb(rd_stb));
  mii_link_properties #(.MDC_HALF(1)) i_mii_link_properties (.clk(clk), .rstn(rstn),
    .rmii_mode(rmii_mode), .speed_100(speed_100), .full_duplex(full_duplex),
    .heartbeat_en(heartbeat_en), .tx_clk(link.tx_clk), .rx_clk(link.rx_clk),
    .tx_en(link.tx_en), .txd(link.txd), .crs(link.crs), .col(link.col),
    .rx_dv(link.rx_dv), .rx_er(link.rx_er), .rxd(link.rxd), .mdc(link.mdc));
  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // outputs are registered, so the falling edge sees them settled
  always @(negedge clk)
  begin
    if (lt_vld === 1'b1) got_tx.push_back({1'b0, lt_nib});
    if (rx_valid === 1'b1) got_rx.push_back({rx_err, rx_nibble});
    if (col === 1'b1) col_seen = 1'b1;
    if (crs === 1'b1) crs_seen = 1'b1;
  end
  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // an errored nibble arrives corrupted; the flag only exists at 100M
  function automatic logic [4:0] exp_rx(input logic [4:0] e);
    exp_rx = {e[4] & speed_100, e[4] ? mii_port_pkg::RX_CORRUPT : e[3:0]};
  endfunction
  // hold each nibble until the mac reports it taken
  task automatic send_tx();
    int i;
    i = 0;
    tx_valid = 1'b1;
    tx_nibble = tx_q[0][3:0];
    while (i < tx_q.size())
    begin
      @(negedge clk);
      if (tx_take === 1'b1)
      begin
        i++;
        tx_valid = (i < tx_q.size());
        tx_nibble = tx_q[i % tx_q.size()][3:0];
      end
    end
  endtask
  task automatic send_rx();
    int i;
    i = 0;
    lr_act = 1'b1;
    lr_vld = 1'b1;
    {lr_err, lr_nib} = rx_q[0];
    while (i < rx_q.size())
    begin
      @(negedge clk);
      if (lr_take === 1'b1)
      begin
        i++;
        lr_vld = (i < rx_q.size());
        {lr_err, lr_nib} = rx_q[i % rx_q.size()];
      end
    end
    // the wrapped index left the clean first entry, so lr_err is already low
    lr_act = 1'b0;
  endtask
  task automatic wait_stb();
    int t;
    t = 0;
    while (rd_stb !== 1'b1 && t < 8)
    begin
      @(negedge clk);
      t++;
    end
  endtask
  // only one end drives mdio at a time, a cycle apart on handover
  task automatic mgmt_check(input logic b);
    logic m;
    {phy_drive, phy_bit} = {1'b1, b};
    repeat (4) @(negedge clk);
    wait_stb();
    check("mdio read", {4'h0, rd_bit}, {4'h0, b});
    phy_drive = 1'b0;
    @(negedge clk);
    {mac_drive, mac_bit} = {1'b1, ~b};
    repeat (6) @(negedge clk);
    check("mdio write", {4'h0, mgmt_mdio}, {4'h0, ~b});
    // a one-clk half period makes the phy's copy of mdc flip every cycle
    m = mgmt_mdc;
    @(negedge clk);
    check("mdc toggle", {4'h0, mgmt_mdc}, {4'h0, ~m});
    mac_drive = 1'b0;
    repeat (6) @(negedge clk);
    wait_stb();
    check("mdio pullup", {4'h0, rd_bit}, 5'h01);
  endtask
  task automatic run_cfg(input logic [4:0] c);
    int n;
    logic ec;
    rstn = 1'b0;
    {rmii_mode, speed_100, full_duplex, heartbeat_en} = c[4:1];
    n = 6 + $urandom_range(6);
    tx_q = '{};
    rx_q = '{{1'b0, 4'hF}};
    got_tx = '{};
    got_rx = '{};
    for (int k = 0; k < n; k++) tx_q.push_back({1'b0, 4'($urandom)});
    for (int k = 1; k < n; k++) rx_q.push_back({$urandom_range(3) == 0, 4'($urandom)});
    rx_q.push_back({1'b1, 4'h0});
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    {col_seen, crs_seen} = 2'h0;
    fork
      send_tx();
      if (c[0]) send_rx();
    join
    repeat (60) @(negedge clk);
    check("tx count", 5'(got_tx.size()), 5'(tx_q.size()));
    for (int k = 0; k < tx_q.size() && k < got_tx.size(); k++)
      check("tx nibble", got_tx[k], tx_q[k]);
    check("rx count", 5'(got_rx.size()), c[0] ? 5'(rx_q.size()) : 5'h00);
    for (int k = 0; c[0] && k < rx_q.size() && k < got_rx.size(); k++)
      check("rx nibble", got_rx[k], exp_rx(rx_q[k]));
    ec = c[4] ? c[0] : (!c[2] && (c[0] || (c[1] && !c[3])));
    check("collision", {4'h0, col_seen}, {4'h0, ec});
    check("carrier", {4'h0, crs_seen}, {4'h0, c[0]});
    mgmt_check(1'($urandom));
  endtask
  // main sequence, a fresh reset per configuration
  initial
  begin
    errors = 0;
    comparisons = 0;
    {lr_act, lr_vld, lr_err, lr_nib, tx_valid, tx_nibble} = 12'h000;
    {phy_drive, phy_bit, mac_drive, mac_bit, col_seen, crs_seen} = 6'h00;
    void'($urandom(30756));
    foreach (CFGS[i]) run_cfg(CFGS[i]);
    complete_run();
  end
  // hang guard, far beyond the thousand or so cycles the run needs
  initial
  begin
    #(40 * 40000);
    errors++;
    complete_run();
  end
endmodule // test_phy_mii_rmii_mac_side_port
`default_nettype wire

// *** verilog/mac_link_end.sv ***
// far end: mac side of the mii/rmii data pins and management master
`timescale 1ns/1ps
`default_nettype none
module mac_link_end #(
  parameter int MDC_HALF = mii_port_pkg::MDC_HALF_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // pins toward the phy
  mii_link_if.mac link,
  // configuration, must match the phy
  input wire logic rmii_mode,
  input wire logic speed_100,
  // transmit stream
  input wire logic tx_valid,
  input wire logic [3:0] tx_nibble,
  output logic tx_take,
  // receive stream
  output logic rx_valid,
  output logic [3:0] rx_nibble,
  output logic rx_err,
  // link status
  output logic crs,
  output logic col,
  // management user side
  input wire logic mgmt_drive,
  input wire logic mgmt_bit,
  output logic mgmt_rd_bit,
  output logic mgmt_rd_stb
);
  localparam int DW = mii_port_pkg::DIV_W;
  localparam int CW = mii_port_pkg::MDC_CNT_W;

  typedef struct packed {
    logic [DW-1:0] div;
    logic rmii;
    logic fast;
    mii_port_pkg::dibit_t tx_ph;
    mii_port_pkg::dibit_t rx_ph;
    logic [1:0] tx_hi;
    logic [1:0] rx_lo;
    logic rx_acc;
    logic [3:0] txd;
    logic tx_en;
    logic tx_take;
    logic [3:0] rx_nib;
    logic rx_vld;
    logic rx_err;
    logic crs;
    logic col;
    logic [CW-1:0] mcnt;
    logic mdc;
    logic mdio_o;
    logic mdio_oe;
    logic rd_bit;
    logic rd_stb;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic ref_tick;
  logic tx_step;
  logic rx_step;

  // rmii has no strobes; same 10x divider as the phy so every dibit is seen once
  assign ref_tick = s_r.fast || (s_r.div == '0);
  assign tx_step = s_r.rmii ? ref_tick : link.tx_clk; // see (R19) (R20)
  assign rx_step = s_r.rmii ? ref_tick : link.rx_clk;

  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tx_take = 1'b0;
    s_nxt.rx_vld = 1'b0;
    s_nxt.rd_stb = 1'b0;
    s_nxt.div = (s_r.div == '0) ? DW'(mii_port_pkg::SLOW_DIV - 1) : s_r.div - DW'(1);
    if (!s_r.tx_en && !tx_valid && !link.rx_dv && !link.crs)
    begin
      s_nxt.rmii = rmii_mode;
      s_nxt.fast = speed_100;
    end
    // transmit: tx_en only while a real nibble or dibit sits on txd
    if (tx_step)
    begin
      if (!s_r.rmii)
      begin
        s_nxt.tx_en = tx_valid; // see (R17)
        s_nxt.txd = tx_valid ? tx_nibble : mii_port_pkg::NIBBLE_IDLE;
        s_nxt.tx_take = tx_valid;
      end
      else if (s_r.tx_ph == mii_port_pkg::DIBIT_HI)
      begin
        s_nxt.txd = {2'b00, s_r.tx_hi};
        s_nxt.tx_ph = mii_port_pkg::DIBIT_LO;
      end
      else
      begin
        s_nxt.tx_en = tx_valid; // see (R18)
        s_nxt.txd = {2'b00, tx_valid ? tx_nibble[1:0] : mii_port_pkg::DIBIT_IDLE};
        s_nxt.tx_hi = tx_nibble[3:2];
        s_nxt.tx_take = tx_valid;
        s_nxt.tx_ph = tx_valid ? mii_port_pkg::DIBIT_HI : mii_port_pkg::DIBIT_LO;
      end
    end
    // receive: mii a nibble per strobe, rmii pairs dibits low first
    if (rx_step)
    begin
      if (!s_r.rmii)
      begin
        s_nxt.rx_vld = link.rx_dv;
        s_nxt.rx_nib = link.rxd;
        s_nxt.rx_err = link.rx_er;
        s_nxt.crs = link.crs;
      end
      else
      begin
        // carrier recovered from crs_dv; a toggle late in a frame is ignored
        s_nxt.crs = link.crs || (s_r.crs && link.rx_dv); // see (R4)
        if (!link.rx_dv)
        begin
          s_nxt.rx_ph = mii_port_pkg::DIBIT_LO;
        end
        else if (s_r.rx_ph == mii_port_pkg::DIBIT_LO)
        begin
          s_nxt.rx_lo = link.rxd[1:0];
          s_nxt.rx_acc = link.rx_er;
          s_nxt.rx_ph = mii_port_pkg::DIBIT_HI;
        end
        else
        begin
          s_nxt.rx_nib = {link.rxd[1:0], s_r.rx_lo};
          s_nxt.rx_err = s_r.rx_acc || link.rx_er;
          s_nxt.rx_vld = 1'b1;
          s_nxt.rx_ph = mii_port_pkg::DIBIT_LO;
        end
      end
    end
    // rmii has no col pin: own tx_en against recovered carrier
    s_nxt.col = s_r.rmii ? (s_nxt.crs && s_nxt.tx_en) : link.col; // see (R4)
    // management clock: half period rounded up keeps it at or under the ceiling
    if (s_r.mcnt == '0) // see (R21)
    begin
      s_nxt.mcnt = CW'(MDC_HALF - 1);
      s_nxt.mdc = !s_r.mdc;
      if (s_r.mdc)
      begin
        // change mdio only while mdc is low
        s_nxt.mdio_o = mgmt_bit;
        s_nxt.mdio_oe = mgmt_drive; // see (R22)
      end
      else
      begin
        s_nxt.rd_bit = link.mdio;
        s_nxt.rd_stb = 1'b1;
      end
    end
    else
    begin
      s_nxt.mcnt = s_r.mcnt - CW'(1);
    end
  end

  // single state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // outputs from the state register
  assign link.tx_en = s_r.tx_en;
  assign link.txd = s_r.txd;
  assign link.mdc = s_r.mdc;
  assign link.mac_mdio_o = s_r.mdio_o;
  assign link.mac_mdio_oe = s_r.mdio_oe;
  assign tx_take = s_r.tx_take;
  assign rx_valid = s_r.rx_vld;
  assign rx_nibble = s_r.rx_nib;
  assign rx_err = s_r.rx_err;
  assign crs = s_r.crs;
  assign col = s_r.col;
  assign mgmt_rd_bit = s_r.rd_bit;
  assign mgmt_rd_stb = s_r.rd_stb;
endmodule // mac_link_end
`default_nettype wire

// *** verilog/mii_link_if.sv ***
// pin-level link between the phy port and the mac end
`timescale 1ns/1ps
`default_nettype none
interface mii_link_if;
  // clock strobes, one clk cycle per nibble, mii only
  logic tx_clk;
  logic rx_clk;
  // transmit path
  logic tx_en;
  logic [3:0] txd;
  // receive path, crs carries crs_dv in rmii
  logic crs;
  logic col;
  logic rx_dv;
  logic rx_er;
  logic [3:0] rxd;
  // management pins, mdio resolved here with its pullup
  logic mdc;
  logic phy_mdio_o;
  logic phy_mdio_oe;
  logic mac_mdio_o;
  logic mac_mdio_oe;
  logic mdio;

  assign mdio = phy_mdio_oe ? phy_mdio_o : (mac_mdio_oe ? mac_mdio_o : 1'b1);

  modport phy (
    output tx_clk, rx_clk, crs, col, rx_dv, rx_er, rxd, phy_mdio_o, phy_mdio_oe,
    input tx_en, txd, mdc, mdio
  );
  modport mac (
    input tx_clk, rx_clk, crs, col, rx_dv, rx_er, rxd, phy_mdio_o, phy_mdio_oe, mdio,
    output tx_en, txd, mdc, mac_mdio_o, mac_mdio_oe
  );
endinterface
`default_nettype wire

// *** verilog/mii_port_pkg.sv ***
// shared constants and types for the mac-side mii/rmii port
`default_nettype none
package mii_port_pkg;
  // reference clock and slow-speed divider
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLOW_LINK_HZ = 2_500_000;
  localparam int SLOW_DIV = CLK_HZ / SLOW_LINK_HZ;
  localparam int DIV_W = 4;
  // heartbeat pulse after transmit end
  localparam int SQE_NS = 1000;
  localparam int SQE_CYC = SQE_NS / CLK_PERIOD_NS;
  localparam int SQE_W = 5;
  // management clock ceiling, half period in clk cycles rounded up
  localparam int MDC_MAX_HZ = 25_000_000;
  localparam int MDC_HALF_CYC = (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ);
  localparam int MDC_CNT_W = 8;
  // nibble forced onto receive data on a line error
  localparam logic [3:0] RX_CORRUPT = 4'hE;
  localparam logic [3:0] NIBBLE_IDLE = 4'h0;
  localparam logic [1:0] DIBIT_IDLE = 2'h0;
  // which half of a nibble an rmii dibit carries
  typedef enum logic {DIBIT_LO, DIBIT_HI} dibit_t;
endpackage
`default_nettype wire

// *** verilog/phy_mac_port.sv ***
// device end: mac-facing mii/rmii data pins and management pin drive
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) half duplex: col while transmit and receive overlap
// (R2) 10M half duplex heartbeat: col pulse after transmit
// (R3) full duplex: col always low, no heartbeat
// (R4) rmii: mac derives collision from crs_dv
// (R5) mii: crs high while receive medium busy
// (R6) rmii: crs pin carries merged carrier and valid
// (R7) mii: receive clock 25 MHz or 2.5 MHz
// (R8) rmii: clock outputs unused, reference times both
// (R9) mii: rx_dv high exactly with valid data
// (R10) rmii: rx_dv shows data validity alone
// (R11) mii 100M: rx_er on invalid symbol
// (R12) rmii 100M: rx_er on media error with rx_dv
// (R13) receive error corrupts delivered receive data
// (R14) mii: 4-bit receive data, valid with rx_dv
// (R15) rmii: receive data on low two bits
// (R16) mii: transmit clock 25 MHz or 2.5 MHz
// (R17) mii: mac tx_en marks valid nibbles exactly
// (R18) rmii: mac tx_en marks valid dibits exactly
// (R19) mii: mac data follows device transmit clock
// (R20) rmii: mac data follows shared reference clock
// (R21) mac management clock at most 25 MHz
// (R22) mdio driven by one side, other releases
// (R23) mode and speed change only while idle
// (R24) launch and sample on interface clock edges
module phy_mac_port (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // mac-side pins
  mii_link_if.phy link,
  // line-side receive stream
  input wire logic line_rx_active,
  input wire logic line_rx_valid,
  input wire logic [3:0] line_rx_nibble,
  input wire logic line_rx_err,
  output logic line_rx_take,
  // line-side transmit stream
  output logic [3:0] line_tx_nibble,
  output logic line_tx_valid,
  // configuration
  input wire logic rmii_mode,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic heartbeat_en,
  // management core side
  input wire logic mgmt_drive,
  input wire logic mgmt_bit,
  output logic mgmt_mdc,
  output logic mgmt_mdio
);
  localparam int DW = mii_port_pkg::DIV_W;
  localparam int SW = mii_port_pkg::SQE_W;

  typedef struct packed {
    logic [DW-1:0] div;
    logic rmii;
    logic fast;
    logic fdx;
    logic hb_en;
    logic tx_clk;
    logic rx_clk;
    mii_port_pkg::dibit_t rx_ph;
    mii_port_pkg::dibit_t tx_ph;
    logic [3:0] rxd;
    logic rx_dv;
    logic rx_er;
    logic crs;
    logic col;
    logic [1:0] tx_lo;
    logic tx_act;
    logic [SW-1:0] sqe;
    logic [3:0] line_tx;
    logic line_tx_vld;
    logic line_rx_take;
    logic mdio_o;
    logic mdio_oe;
    logic mdc_seen;
    logic mdio_seen;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic tick;
  logic [3:0] rx_nib;
  logic [1:0] rx_dibit;

  // nibble tick: every clk at 100M, one in ten at 10M
  assign tick = s_r.fast || (s_r.div == '0);

  // error replaces the whole nibble so the frame check fails downstream
  assign rx_nib = line_rx_err ? mii_port_pkg::RX_CORRUPT : line_rx_nibble; // see (R13)
  assign rx_dibit = (s_r.rx_ph == mii_port_pkg::DIBIT_LO) ? rx_nib[1:0] : rx_nib[3:2];

  // next-state logic for the whole port
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.line_rx_take = 1'b0;
    s_nxt.line_tx_vld = 1'b0;
    if (s_r.div == '0)
    begin
      s_nxt.div = DW'(mii_port_pkg::SLOW_DIV - 1);
    end
    else
    begin
      s_nxt.div = s_r.div - DW'(1);
    end
    // switching mid-frame would split a nibble, so only take it when quiet
    if (!line_rx_active && !line_rx_valid && !link.tx_en && !s_r.tx_act) // see (R23)
    begin
      s_nxt.rmii = rmii_mode;
      s_nxt.fast = speed_100;
      s_nxt.fdx = full_duplex;
      s_nxt.hb_en = heartbeat_en;
    end
    // strobes only exist in mii; rmii runs off the reference clock
    s_nxt.tx_clk = !s_r.rmii && tick; // see (R7) (R16) (R8)
    s_nxt.rx_clk = !s_r.rmii && tick; // see (R7) (R8)
    if (s_r.sqe != '0)
    begin
      s_nxt.sqe = s_r.sqe - SW'(1);
    end
    if (tick) // see (R24)
    begin
      if (!s_r.rmii)
      begin
        // mii receive: a nibble per tick, data only under rx_dv
        s_nxt.rxd = line_rx_valid ? rx_nib : mii_port_pkg::NIBBLE_IDLE; // see (R14)
        s_nxt.rx_dv = line_rx_valid; // see (R9)
        s_nxt.rx_er = line_rx_valid && line_rx_err && s_r.fast; // see (R11)
        s_nxt.crs = line_rx_active; // see (R5)
        s_nxt.line_rx_take = line_rx_valid;
        // mii transmit: one nibble straight through per tick
        s_nxt.line_tx = link.txd;
        s_nxt.line_tx_vld = link.tx_en;
      end
      else
      begin
        // rmii receive: low dibit first, high bits of rxd held at zero
        s_nxt.rxd = {2'b00, line_rx_valid ? rx_dibit : mii_port_pkg::DIBIT_IDLE}; // see (R15)
        s_nxt.rx_dv = line_rx_valid; // see (R10)
        s_nxt.rx_er = line_rx_valid && line_rx_err && s_r.fast; // see (R12)
        // after carrier drops crs_dv toggles on dibit halves while data drains
        s_nxt.crs = line_rx_active ||
          (line_rx_valid && s_r.rx_ph == mii_port_pkg::DIBIT_LO); // see (R6)
        if (!line_rx_valid)
        begin
          s_nxt.rx_ph = mii_port_pkg::DIBIT_LO;
        end
        else if (s_r.rx_ph == mii_port_pkg::DIBIT_LO)
        begin
          s_nxt.rx_ph = mii_port_pkg::DIBIT_HI;
        end
        else
        begin
          s_nxt.rx_ph = mii_port_pkg::DIBIT_LO;
          s_nxt.line_rx_take = 1'b1;
        end
        // rmii transmit: pair two dibits, low first, into a nibble
        if (!link.tx_en) // see (R18)
        begin
          s_nxt.tx_ph = mii_port_pkg::DIBIT_LO;
        end
        else if (s_r.tx_ph == mii_port_pkg::DIBIT_LO)
        begin
          s_nxt.tx_lo = link.txd[1:0];
          s_nxt.tx_ph = mii_port_pkg::DIBIT_HI;
        end
        else
        begin
          s_nxt.line_tx = {link.txd[1:0], s_r.tx_lo};
          s_nxt.line_tx_vld = 1'b1;
          s_nxt.tx_ph = mii_port_pkg::DIBIT_LO;
        end
      end
      s_nxt.tx_act = link.tx_en;
      // falling edge of tx_en at 10M half duplex starts the heartbeat
      if (s_r.tx_act && !link.tx_en && !s_r.rmii && !s_r.fast &&
        !s_r.fdx && s_r.hb_en) // see (R2)
      begin
        s_nxt.sqe = SW'(mii_port_pkg::SQE_CYC);
      end
    end
    // no col pin in rmii, so hold it low there too
    s_nxt.col = !s_r.rmii && !s_r.fdx && // see (R3) (R4)
      ((link.tx_en && line_rx_active) || s_nxt.sqe != '0); // see (R1) (R2)
    // management pins: drive only when the core asks, release otherwise
    s_nxt.mdio_o = mgmt_bit;
    s_nxt.mdio_oe = mgmt_drive; // see (R22)
    s_nxt.mdc_seen = link.mdc;
    s_nxt.mdio_seen = link.mdio;
  end

  // single state register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // pin and user outputs, all straight from the state register
  assign link.tx_clk = s_r.tx_clk;
  assign link.rx_clk = s_r.rx_clk;
  assign link.crs = s_r.crs;
  assign link.col = s_r.col;
  assign link.rx_dv = s_r.rx_dv;
  assign link.rx_er = s_r.rx_er;
  assign link.rxd = s_r.rxd;
  assign link.phy_mdio_o = s_r.mdio_o;
  assign link.phy_mdio_oe = s_r.mdio_oe;
  assign line_rx_take = s_r.line_rx_take;
  assign line_tx_nibble = s_r.line_tx;
  assign line_tx_valid = s_r.line_tx_vld;
  assign mgmt_mdc = s_r.mdc_seen;
  assign mgmt_mdio = s_r.mdio_seen;
endmodule // phy_mac_port
`default_nettype wire
